//--- hdl/afifo_port_pkg.sv
// package: shared types and constants for the async parallel fifo port
`default_nettype none
package afifo_port_pkg;
   localparam int DATA_W        = 8;
   localparam int TX_DEPTH      = 8;
   localparam int RX_DEPTH      = 8;
   localparam int SYNC_STAGES   = 2;
   localparam int CLK_HZ        = 20_000_000;
   // minimum strobe low time seen by the core, in ns
   localparam int STROBE_MIN_NS = 100;
   localparam int STROBE_MIN_CYC =
      ((STROBE_MIN_NS * (CLK_HZ / 1_000_000)) + 999) / 1000;
   localparam logic [7:0] DATA_RST = 8'h00;

   // byte with its valid flag
   typedef struct packed {
      logic       vld;
      logic [7:0] data;
   } byte_t;

   // pin group of one channel, raw or synchronised
   typedef struct packed {
      logic rd_n;
      logic wr_n;
      logic send_now_wakeup_n_n;
   } strobes_t;

   typedef enum logic [1:0] {
      RD_IDLE  = 2'b00,
      RD_DRIVE = 2'b01,
      RD_DONE  = 2'b11
   } rd_state_t;
endpackage
`default_nettype wire

//--- hdl/async_parallel_fifo_port.sv
// module: strobe-driven byte fifo port of one bridge channel
`default_nettype none
module async_parallel_fifo_port
   import afifo_port_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_mode_en,
   input  wire logic        i_remote_wake_en,
   input  wire logic        i_usb_suspended,
   input  wire logic        i_rd_n,
   input  wire logic        i_wr_n,
   input  wire logic        i_send_now_wakeup_n,
   input  wire logic [7:0]  i_chan_data,
   output logic [7:0]       o_chan_data,
   output logic             o_chan_data_oe,
   output logic             o_rx_avail_n,
   output logic             o_rx_avail_oe,
   output logic             o_tx_space_n,
   output logic             o_tx_space_oe,
   output logic             o_usb_active_n,
   input  wire logic        i_usb_rx_valid,
   output logic             o_usb_rx_ready,
   input  wire logic [7:0]  i_usb_rx_data,
   output logic             o_usb_tx_valid,
   input  wire logic        i_usb_tx_ready,
   output logic [7:0]       o_usb_tx_data,
   output logic             o_send_now,
   output logic             o_resume_req
);
   strobes_t  pins_raw;
   strobes_t  pins;
   strobes_t  prev_q;
   logic [7:0] data_meta_q;
   logic [7:0] data_sync_q;
   logic      rd_fall;
   logic      rd_rise;
   logic      wr_fall;
   logic      send_now_wakeup_n_fall;
   rd_state_t rd_state_q;
   rd_state_t rd_state_d;
   logic      rx_in_ready;
   logic      rx_out_valid;
   logic      rx_pop;
   logic [7:0] rx_head;
   logic      tx_in_ready;
   logic      tx_out_valid;
   logic [7:0] tx_head;
   logic      tx_push;
   logic [3:0] rx_cnt;
   logic [3:0] tx_cnt;

   // =====================================================
   // pin synchronisers
   assign pins_raw = '{rd_n: i_rd_n, wr_n: i_wr_n, send_now_wakeup_n_n: i_send_now_wakeup_n};

   pin_sync u_sync (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_pins  (pins_raw),
      .o_pins  (pins)
   );

   // data bus sampling, two stages
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         data_meta_q <= DATA_RST;
         data_sync_q <= DATA_RST;
      end else begin
         data_meta_q <= i_chan_data;
         data_sync_q <= data_meta_q;
      end
   end

   // edge detection on synchronised strobes
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         prev_q <= '1;
      end else begin
         prev_q <= pins;
      end
   end

   assign rd_fall   = i_mode_en && prev_q.rd_n && !pins.rd_n;
   assign rd_rise   = i_mode_en && !prev_q.rd_n && pins.rd_n;
   assign wr_fall   = i_mode_en && prev_q.wr_n && !pins.wr_n;
   assign send_now_wakeup_n_fall = i_mode_en && prev_q.send_now_wakeup_n_n && !pins.send_now_wakeup_n_n;

   // =====================================================
   // receive path: usb side fills, read strobe drains
   byte_fifo #(.WIDTH(DATA_W), .DEPTH(RX_DEPTH)) u_rx_fifo (
      .i_clk       (i_clk),
      .i_rst_n     (i_rst_n),
      .i_in_valid  (i_usb_rx_valid && o_usb_rx_ready && rx_in_ready),
      .o_in_ready  (rx_in_ready),
      .i_in_data   (i_usb_rx_data),
      .o_out_valid (rx_out_valid),
      .i_out_ready (rx_pop),
      .o_out_data  (rx_head),
      .o_count     (rx_cnt)
   );

   // read state machine
   always_comb begin
      rd_state_d = rd_state_q;
      unique case (rd_state_q)
         RD_IDLE: begin
            if (rd_fall && rx_out_valid) begin
               rd_state_d = RD_DRIVE;
            end
         end
         RD_DRIVE: begin
            if (rd_rise) begin
               rd_state_d = RD_DONE;
            end
         end
         RD_DONE: begin
            rd_state_d = RD_IDLE;
         end
         default: rd_state_d = RD_IDLE;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rd_state_q <= RD_IDLE;
      end else begin
         rd_state_q <= rd_state_d;
      end
   end

   assign rx_pop = (rd_state_q == RD_DRIVE) && rd_rise;

   // bus drive while read strobe low
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_chan_data    <= DATA_RST;
         o_chan_data_oe <= 1'b0;
      end else begin
         if (rd_fall) begin
            o_chan_data <= rx_head;
         end
         o_chan_data_oe <= i_mode_en && !pins.rd_n;
      end
   end

   // receive flag: forced high from the cycle after the read fall until done, then reflects data
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_rx_avail_n  <= 1'b1;
         o_rx_avail_oe <= 1'b0;
      end else begin
         o_rx_avail_oe <= i_mode_en;
         if (rd_rise || rd_state_q == RD_DONE || !pins.rd_n) begin
            o_rx_avail_n <= (rd_state_q == RD_DRIVE) ? 1'b1 : o_rx_avail_n;
         end else begin
            o_rx_avail_n <= !rx_out_valid;
         end
      end
   end

   // =====================================================
   // transmit path: write strobe fills, usb side drains
   assign tx_push = wr_fall && tx_in_ready;

   byte_fifo #(.WIDTH(DATA_W), .DEPTH(TX_DEPTH)) u_tx_fifo (
      .i_clk       (i_clk),
      .i_rst_n     (i_rst_n),
      .i_in_valid  (tx_push),
      .o_in_ready  (tx_in_ready),
      .i_in_data   (data_sync_q),
      .o_out_valid (tx_out_valid),
      .i_out_ready (i_usb_tx_ready),
      .o_out_data  (tx_head),
      .o_count     (tx_cnt)
   );

   // usb-side outputs and transmit flag
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_usb_rx_ready <= 1'b0;
         o_usb_tx_valid <= 1'b0;
         o_usb_tx_data  <= DATA_RST;
         o_tx_space_n   <= 1'b1;
         o_tx_space_oe  <= 1'b0;
      end else begin
         // ready drops one entry early so the registered flag never overfills
         o_usb_rx_ready <= i_mode_en && (rx_cnt < 4'(RX_DEPTH - 1));
         // shows the byte taken by the usb side at this same edge
         o_usb_tx_valid <= tx_out_valid;
         o_usb_tx_data  <= tx_head;
         o_tx_space_oe  <= i_mode_en;
         // flag goes high on the write and stays until strobe released
         o_tx_space_n   <= !tx_in_ready || wr_fall || !pins.wr_n;
      end
   end

   // send-immediate and wakeup
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_send_now     <= 1'b0;
         o_resume_req   <= 1'b0;
         o_usb_active_n <= 1'b1;
      end else begin
         o_usb_active_n <= i_usb_suspended;
         o_resume_req   <= send_now_wakeup_n_fall && i_usb_suspended && i_remote_wake_en;
         o_send_now     <= send_now_wakeup_n_fall && !i_usb_suspended;
      end
   end

   // =====================================================
   // checks
   a_bus_drive_rule : assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_chan_data_oe |-> $past(!pins.rd_n)) else $error("bus driven without read");

   a_rx_flag_valid : assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (!o_rx_avail_n && o_rx_avail_oe) |-> $past(rx_out_valid) || rx_cnt != '0)
      else $error("rx flag low without data");

   a_rx_flag_rise : assert property (@(posedge i_clk) disable iff (!i_rst_n)
      rx_pop |=> o_rx_avail_n) else $error("rx flag not forced high");

   a_rx_advance : assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (rd_state_q == RD_DRIVE && rd_rise) |-> rx_pop) else $error("no advance");

   a_rd_present : assert property (@(posedge i_clk) disable iff (!i_rst_n)
      rd_fall |=> o_chan_data == $past(rx_head)) else $error("wrong byte shown");

   a_tx_flag_full : assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !tx_in_ready |=> o_tx_space_n) else $error("tx flag low while full");

   a_tx_capture : assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (wr_fall && tx_in_ready) |=> tx_cnt == $past(tx_cnt) + 4'h1
         || $past(i_usb_tx_ready && tx_out_valid)) else $error("write lost");

   a_mode_gate : assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !i_mode_en |=> !o_rx_avail_oe && !o_tx_space_oe) else $error("flags driven");

   a_resume_req : assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (send_now_wakeup_n_fall && i_usb_suspended && i_remote_wake_en) |=> o_resume_req)
      else $error("resume missed");

   a_send_now : assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_send_now |-> $past(!i_usb_suspended)) else $error("flush while suspended");

   a_flags_reset : assert property (@(posedge i_clk)
      !$past(i_rst_n) |-> !o_rx_avail_oe && !o_tx_space_oe)
      else $error("flags driven after reset");

   c_read_byte  : cover property (@(posedge i_clk) disable iff (!i_rst_n) rx_pop);
   c_write_byte : cover property (@(posedge i_clk) disable iff (!i_rst_n) tx_push);
   c_tx_full    : cover property (@(posedge i_clk) disable iff (!i_rst_n) !tx_in_ready);
   c_wakeup     : cover property (@(posedge i_clk) disable iff (!i_rst_n) o_resume_req);
endmodule
`default_nettype wire

//--- hdl/byte_fifo.sv
// module: small synchronous fifo with valid/ready on both sides
`default_nettype none
module byte_fifo
   import afifo_port_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic [WIDTH-1:0]      o_out_data,
   output logic [$clog2(DEPTH):0] o_count
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_ptr_q;
   logic [AW-1:0]    rd_ptr_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   // =====================================================
   // handshake terms
   assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign o_out_valid = (cnt_q != '0);
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;
   assign o_out_data  = mem_q[rd_ptr_q];
   assign o_count     = cnt_q;

   // storage
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= i_in_data;
      end
   end

   // pointers and fill level
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q    <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   a_fifo_no_overflow : assert property (@(posedge i_clk) disable iff (!i_rst_n)
      cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule
`default_nettype wire

//--- hdl/pin_sync.sv
// module: two-stage synchroniser for a group of strobe pins
`default_nettype none
module pin_sync
   import afifo_port_pkg::*;
(
   input  wire logic     i_clk,
   input  wire logic     i_rst_n,
   input  wire strobes_t i_pins,
   output strobes_t      o_pins
);
   strobes_t meta_q;
   strobes_t sync_q;

   // idle level of every strobe is high
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         meta_q <= '1;
         sync_q <= '1;
      end else begin
         meta_q <= i_pins;
         sync_q <= meta_q;
      end
   end
   assign o_pins = sync_q;
endmodule
`default_nettype wire

//--- verif/ctrl_model.sv
// partner model: external controller that strobes the fifo port
`default_nettype none
module ctrl_model (
   input  wire logic       i_clk,
   input  wire logic       i_rx_avail_n,
   input  wire logic       i_tx_space_n,
   input  wire logic       i_bus_oe,
   input  wire logic [7:0] i_bus,
   output logic            o_rd_n,
   output logic            o_wr_n,
   output logic            o_send_now_wakeup_n_n,
   output logic [7:0]      o_data
);
   timeunit 1ns;
   timeprecision 1ns;
   // strobes idle high from time zero
   initial begin
      o_rd_n   = 1'b1;
      o_wr_n   = 1'b1;
      o_send_now_wakeup_n_n = 1'b1;
      o_data   = 8'h00;
   end
   // wait, strobes idle, until the chosen flag is low
   task automatic wait_flag(input bit rx);
      int n;
      n = 0;
      while ((rx ? i_rx_avail_n : i_tx_space_n) !== 1'b0 && n < 200) begin
         @(posedge i_clk);
         n++;
      end
   endtask
   // one read pulse: sample bus while low, watch flag after rise
   task automatic rd(output logic [7:0] d, output logic oe, output logic hi);
      wait_flag(1'b1);
      @(posedge i_clk);
      o_rd_n <= 1'b0;
      repeat (6) @(posedge i_clk);
      d  = i_bus;
      oe = i_bus_oe;
      hi = 1'b0;
      o_rd_n <= 1'b1;
      repeat (6) begin
         @(posedge i_clk);
         if (i_rx_avail_n === 1'b1) hi = 1'b1;
      end
   endtask
   // one write pulse, byte held through the low phase
   task automatic wr(input logic [7:0] b);
      wait_flag(1'b0);
      @(posedge i_clk);
      o_data <= b;
      o_wr_n <= 1'b0;
      repeat (6) @(posedge i_clk);
      o_wr_n <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_data <= ~b; // released bus shows no stale byte
   endtask
   // one low strobe on the send-now/wakeup pin
   task automatic send_now_wakeup_n();
      @(posedge i_clk);
      o_send_now_wakeup_n_n <= 1'b0;
      repeat (6) @(posedge i_clk);
      o_send_now_wakeup_n_n <= 1'b1;
      repeat (6) @(posedge i_clk);
   endtask
endmodule
`default_nettype wire

//--- verif/tb.sv
// testbench: async parallel fifo port against the controller model
`default_nettype none
module tb;
   import afifo_port_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk = 1'b0, rst_n = 1'b0, mode_en = 1'b1, wake_en = 1'b0, susp = 1'b0;
   logic       rx_valid = 1'b0, tx_ready = 1'b0, rd_n, wr_n, send_now_wakeup_n_n, rx_ready, tx_valid;
   logic [7:0] rx_data = 8'h00, m_data, d_out, tx_data, bus, d;
   logic       d_oe, rxf_n, rxf_oe, txe_n, txe_oe, act_n, send_now, resume, oe, hi;
   int         n_fail = 0, check_count = 0, n_send = 0, n_res = 0;
   // 20 MHz clock
   always #25 clk = ~clk;
   assign bus = d_oe ? d_out : m_data;
   // count one-cycle pulses
   always @(posedge clk) begin
      if (send_now === 1'b1) n_send <= n_send + 1;
      if (resume === 1'b1) n_res <= n_res + 1;
   end
   async_parallel_fifo_port u_async_parallel_fifo_port (
      .i_clk(clk), .i_rst_n(rst_n), .i_mode_en(mode_en), .i_remote_wake_en(wake_en),
      .i_usb_suspended(susp), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_send_now_wakeup_n(send_now_wakeup_n_n),
      .i_chan_data(bus), .o_chan_data(d_out), .o_chan_data_oe(d_oe),
      .o_rx_avail_n(rxf_n), .o_rx_avail_oe(rxf_oe), .o_tx_space_n(txe_n),
      .o_tx_space_oe(txe_oe), .o_usb_active_n(act_n), .i_usb_rx_valid(rx_valid),
      .o_usb_rx_ready(rx_ready), .i_usb_rx_data(rx_data), .o_usb_tx_valid(tx_valid),
      .i_usb_tx_ready(tx_ready), .o_usb_tx_data(tx_data), .o_send_now(send_now),
      .o_resume_req(resume));
   ctrl_model u_ctrl_model (
      .i_clk(clk), .i_rx_avail_n(rxf_n), .i_tx_space_n(txe_n), .i_bus_oe(d_oe),
      .i_bus(bus), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_send_now_wakeup_n_n(send_now_wakeup_n_n), .o_data(m_data));
   // compare one value
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // hand one byte in from the usb side
   task automatic push(input logic [7:0] b);
      int n;
      n = 0;
      rx_valid <= 1'b1;
      rx_data  <= b;
      do begin
         @(posedge clk);
         n++;
      end while (rx_ready !== 1'b1 && n < 50);
      rx_valid <= 1'b0;
      @(posedge clk); // valid low for one edge before the next byte
      if (n >= 50) n_fail++;
   endtask
   // flags undriven in reset, then idle levels
   task automatic t_reset();
      repeat (3) @(posedge clk);
      chk("rxf_oe", 8'h00, {7'h0, rxf_oe});
      chk("txe_oe", 8'h00, {7'h0, txe_oe});
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      chk("rxf_idle", 8'h01, {7'h0, rxf_n});
      chk("txe_idle", 8'h00, {7'h0, txe_n});
      chk("bus_oe", 8'h00, {7'h0, d_oe});
   endtask
   // two back-to-back reads
   task automatic t_rx();
      push(8'ha5);
      push(8'h3c);
      u_ctrl_model.rd(d, oe, hi);
      chk("rd0", 8'ha5, d);
      chk("rd0_oe", 8'h01, {7'h0, oe});
      chk("rd0_flag", 8'h01, {7'h0, hi});
      u_ctrl_model.rd(d, oe, hi);
      chk("rd1", 8'h3c, d);
      chk("rxf_empty", 8'h01, {7'h0, rxf_n});
      chk("bus_off", 8'h00, {7'h0, d_oe});
   endtask
   // fill tx buffer to full, then drain it and check every byte
   task automatic t_tx();
      for (int i = 0; i < TX_DEPTH; i++) u_ctrl_model.wr(8'h10 + 8'(i));
      repeat (4) @(posedge clk);
      chk("txe_full", 8'h01, {7'h0, txe_n});
      tx_ready <= 1'b1;
      @(posedge clk);
      // each edge shows the byte taken at the edge before
      for (int i = 0; i < TX_DEPTH; i++) begin
         @(posedge clk);
         chk("tx_byte", 8'h10 + 8'(i), tx_data);
      end
      tx_ready <= 1'b0;
      repeat (3) @(posedge clk);
      chk("txe_drained", 8'h00, {7'h0, txe_n});
   endtask
   // send-now and wakeup strobes in each link state
   task automatic t_send_now_wakeup_n();
      wake_en <= 1'b1;
      u_ctrl_model.send_now_wakeup_n();
      chk("send_now", 8'h01, 8'(n_send));
      chk("no_resume", 8'h00, 8'(n_res));
      susp <= 1'b1;
      repeat (3) @(posedge clk);
      chk("usb_active_n", 8'h01, {7'h0, act_n});
      u_ctrl_model.send_now_wakeup_n();
      chk("resume", 8'h01, 8'(n_res));
      wake_en <= 1'b0;
      u_ctrl_model.send_now_wakeup_n();
      chk("resume_off", 8'h01, 8'(n_res));
      chk("send_susp", 8'h01, 8'(n_send));
   endtask
   // mode off leaves flags undriven
   task automatic t_mode();
      mode_en <= 1'b0;
      repeat (4) @(posedge clk);
      chk("rxf_oe_off", 8'h00, {7'h0, rxf_oe});
      chk("txe_oe_off", 8'h00, {7'h0, txe_oe});
   endtask
   // verdict and end of run
   task automatic final_report();
      if (n_fail == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // main sequence
   initial begin
      t_reset();
      t_rx();
      t_tx();
      t_send_now_wakeup_n();
      t_mode();
      final_report();
   end
   // watchdog, well past the expected run
   initial begin
      #300000;
      n_fail++;
      final_report();
   end
endmodule
`default_nettype wire
